// >>> rtl/boot_pkg.sv
// Constants, register map and types of the tile boot loader
package boot_pkg;
  // Clock and timing
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned INT_RESET_US      = 15;
  localparam int unsigned INT_RESET_CYC     = INT_RESET_US * CLK_MHZ;
  // Image format
  localparam logic [31:0] NO_CRC_MAGIC      = 32'h0D15AB1E;
  localparam logic [31:0] CRC_POLY          = 32'hEDB88320;
  localparam logic [31:0] CRC_PRESET        = 32'hFFFFFFFF;
  localparam logic [1:0]  BYTE_LAST         = 2'h3;
  // OTP organisation
  localparam int unsigned OTP_ROWS          = 2048;
  localparam int unsigned OTP_AW            = 11;
  localparam logic [10:0] OTP_SEC_ROW       = 11'h7FF;
  localparam logic [10:0] OTP_IMG_ROW       = 11'h000;
  localparam int unsigned SECTOR_SHIFT      = 9;
  // RAM
  localparam int unsigned RAM_AW            = 16;
  localparam logic [15:0] RAM_BASE          = 16'h0000;
  // Register offsets (word index on the bus, not byte addresses)
  localparam logic [3:0]  REG_SECURITY      = 4'h0;
  localparam logic [3:0]  REG_STATUS        = 4'h1;
  localparam logic [3:0]  REG_OTP_PROG      = 4'h2;
  localparam logic [3:0]  REG_OTP_PDATA     = 4'h3;
  localparam logic [3:0]  REG_CRC           = 4'h4;
  // Security fields
  localparam int unsigned SEC_JTAG_DIS      = 0;
  localparam int unsigned SEC_LINK_DIS      = 1;
  localparam int unsigned SEC_SECURE_BOOT   = 5;
  localparam int unsigned SEC_REDUNDANT     = 7;
  localparam int unsigned SEC_LOCK0         = 8;
  localparam int unsigned SEC_MASTER_LOCK   = 12;
  localparam int unsigned SEC_JTAG_OTP_DIS  = 13;
  localparam int unsigned SEC_DEBUG_DIS     = 14;
  localparam int unsigned SEC_USER_LO       = 15;
  localparam int unsigned SEC_USER_HI       = 21;
  localparam int unsigned SEC_CODE_LO       = 22;
  localparam logic [31:0] SEC_RESET         = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ     = 32'h00000000;
  // Boot states, one-hot
  typedef enum logic [8:0] {
    ST_RESET   = 9'h001,
    ST_SECLOAD = 9'h002,
    ST_SIZE    = 9'h004,
    ST_BODY    = 9'h008,
    ST_CHECK   = 9'h010,
    ST_VERIFY  = 9'h020,
    ST_RUN     = 9'h040,
    ST_FAIL    = 9'h080,
    ST_WAIT    = 9'h100
  } boot_state_t;
endpackage

// >>> rtl/boot_crc32.sv
// Byte-wide reflected CRC-32 engine
`timescale 1ns/100ps
module boot_crc32
  import boot_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        init_i,
  input  wire logic        byte_vld_i,
  input  wire logic [7:0]  byte_i,
  // Result
  output logic      [31:0] crc_o
);
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  // Eight reflected shifts per byte
  always_comb
  begin
    crc_nxt = crc_r ^ {24'h000000, byte_i};
    for (int i = 0; i < 8; i++)
    begin
      crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ CRC_POLY) : (crc_nxt >> 1);
    end
  end

  // Register with preset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      crc_r <= CRC_PRESET;
    else if (init_i)
      crc_r <= CRC_PRESET;
    else if (byte_vld_i)
      crc_r <= crc_nxt;
  end

  // Inverted residue is the result
  assign crc_o = ~crc_r;
endmodule

// >>> rtl/boot_flash_src.sv
// Serial flash byte fetcher with request/valid handshake
`timescale 1ns/100ps
module boot_flash_src
  import boot_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Loader side
  input  wire logic        start_i,
  input  wire logic        req_i,
  output logic             vld_o,
  output logic      [7:0]  byte_o,
  // Flash side
  output logic             fl_rd_o,
  output logic      [23:0] fl_addr_o,
  input  wire logic        fl_vld_i,
  input  wire logic [7:0]  fl_data_i
);
  logic [23:0] addr_r;
  logic        busy_r;
  logic        rd_r;

  // Registered read strobe, one pulse per byte
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_r <= 1'b0;
    else
      rd_r <= req_i && !busy_r && !start_i;
  end

  // Sequential address, one read outstanding
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      addr_r <= 24'h000000;
      busy_r <= 1'b0;
    end
    else if (start_i)
    begin
      addr_r <= 24'h000000;
      busy_r <= 1'b0;
    end
    else if (busy_r && fl_vld_i)
    begin
      addr_r <= addr_r + 24'h000001;
      busy_r <= 1'b0;
    end
    else if (req_i && !busy_r)
      busy_r <= 1'b1;
  end

  assign fl_rd_o   = rd_r;
  assign fl_addr_o = addr_r;
  assign vld_o     = busy_r && fl_vld_i;
  assign byte_o    = fl_data_i;
endmodule

// >>> rtl/tile_boot_loader.sv
// Tile boot sequencer, image loader and security register
//
// Behaviour
// - Hold in reset, pull down all GPIO
// - Internal reset delay before booting starts
// - Security bit 5 selects OTP boot source
// - Image is size, size*4 bytes, check word
// - Magic check value skips CRC verification
// - Size and check assembled LSB first
// - Load at lowest RAM address, run there
// - CRC covers size bytes and program bytes
// - Reflected CRC-32, preset ones, inverted result
// - Bit 0 blocks scan port tile access
// - Bit 1 blocks switch access to processor
// - Secure boot starts from OTP address zero
// - Bit 7 enables OTP redundant rows
// - Bits 8-11 lock OTP sectors 0-3
// - Bit 12 blocks all OTP programming
// - Bit 13 blocks scan port OTP access
// - Bit 14 disables debug sync pin
// - User field 21:15, scan code 31:22
// - Security register loaded from OTP first
// - OTP is four sectors of 512 words
// - OTP contents copied to SRAM, run first
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module tile_boot_loader
  import boot_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Serial flash byte port
  output logic             FL_RD_O,
  output logic      [23:0] FL_ADDR_O,
  input  wire logic        FL_VLD_I,
  input  wire logic [7:0]  FL_DATA_I,
  // OTP read and program port
  output logic      [10:0] OTP_ADDR_O,
  input  wire logic [31:0] OTP_RDATA_I,
  output logic             OTP_PROG_O,
  output logic      [31:0] OTP_WDATA_O,
  output logic             OTP_REDUNDANT_O,
  // RAM write port
  output logic             RAM_WE_O,
  output logic      [15:0] RAM_ADDR_O,
  output logic      [7:0]  RAM_WDATA_O,
  // Processor control
  output logic             CPU_RUN_O,
  output logic      [15:0] CPU_PC_O,
  output logic             BOOT_FAIL_O,
  // Security gates
  output logic             GPIO_PULLDOWN_O,
  output logic             JTAG_TILE_EN_O,
  output logic             LINK_ACCESS_EN_O,
  output logic             JTAG_OTP_EN_O,
  output logic             DEBUG_PIN_EN_O,
  output logic      [9:0]  SCAN_USER_CODE_EXT_O
);
  boot_state_t state_r;
  logic [31:0] sec_r;
  logic [15:0] dly_r;
  logic [31:0] shift_r;
  logic [1:0]  bcnt_r;
  logic [31:0] words_r;
  logic [31:0] left_r;
  logic [15:0] ram_addr_r;
  logic [10:0] otp_addr_r;
  logic        otp_pend_r;
  logic        from_otp_r;
  logic [31:0] prog_data_r;
  logic        prog_r;
  logic        wait_r;
  logic [10:0] prog_row_r;
  logic        ram_we_r;
  logic [7:0]  ram_wd_r;
  logic        src_vld;
  logic [7:0]  src_byte;
  logic        fl_vld;
  logic [7:0]  fl_byte;
  logic        fl_start;
  logic        fl_req;
  logic [31:0] crc;
  logic        crc_init;
  logic        crc_feed;
  logic [31:0] word_nxt;
  logic        in_stream;

  // OTP row to sector index
  function automatic logic [1:0] sector_of(input logic [10:0] row);
    sector_of = row[SECTOR_SHIFT +: 2];
  endfunction

  // Programming allowed when sector and master unlocked
  function automatic logic prog_ok(input logic [31:0] sec, input logic [10:0] row);
    prog_ok = !sec[SEC_MASTER_LOCK] && !sec[SEC_LOCK0 + sector_of(row)];
  endfunction

  assign in_stream = (state_r == ST_SIZE) || (state_r == ST_BODY) || (state_r == ST_CHECK);
  assign fl_start  = (state_r == ST_SECLOAD);
  assign fl_req    = in_stream && !from_otp_r && !ram_we_r;

  // Byte fetcher for the embedded flash
  boot_flash_src u_flash
  (
    .clk_i     (CLK_SYS_I),
    .rst_n_i   (RST_N_I),
    .start_i   (fl_start),
    .req_i     (fl_req),
    .vld_o     (fl_vld),
    .byte_o    (fl_byte),
    .fl_rd_o   (FL_RD_O),
    .fl_addr_o (FL_ADDR_O),
    .fl_vld_i  (FL_VLD_I),
    .fl_data_i (FL_DATA_I)
  );

  // Byte source: OTP word sliced LSB first, or flash
  always_comb
  begin
    if (from_otp_r)
    begin
      src_vld  = in_stream && otp_pend_r && !ram_we_r;
      src_byte = OTP_RDATA_I[{bcnt_r, 3'h0} +: 8];
    end
    else
    begin
      src_vld  = fl_vld;
      src_byte = fl_byte;
    end
  end

  assign word_nxt = {src_byte, shift_r[31:8]};
  assign crc_init = (state_r == ST_SECLOAD);
  assign crc_feed = src_vld && ((state_r == ST_SIZE) || (state_r == ST_BODY));

  // CRC engine
  boot_crc32 u_crc
  (
    .clk_i      (CLK_SYS_I),
    .rst_n_i    (RST_N_I),
    .init_i     (crc_init),
    .byte_vld_i (crc_feed),
    .byte_i     (src_byte),
    .crc_o      (crc)
  );

  // Boot sequencer
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state_r <= ST_RESET;
    else
      case (state_r)
        ST_RESET:   if (dly_r == INT_RESET_CYC[15:0]) state_r <= ST_SECLOAD;
        ST_SECLOAD: state_r <= ST_SIZE;
        ST_SIZE:    if (src_vld && bcnt_r == BYTE_LAST)
                      state_r <= (word_nxt == 32'h00000000) ? ST_CHECK : ST_BODY;
        ST_BODY:    if (src_vld && bcnt_r == BYTE_LAST && left_r == 32'h00000001) state_r <= ST_CHECK;
        ST_CHECK:   if (src_vld && bcnt_r == BYTE_LAST) state_r <= ST_VERIFY;
        ST_VERIFY:  state_r <= (shift_r == NO_CRC_MAGIC || shift_r == crc) ? ST_RUN : ST_FAIL;
        ST_RUN:     state_r <= ST_RUN;
        ST_FAIL:    state_r <= ST_FAIL;
        ST_WAIT:    state_r <= ST_RESET;
        default:    state_r <= ST_RESET;
      endcase
  end

  // Internal reset delay counter
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      dly_r <= 16'h0000;
    else if (state_r == ST_RESET)
      dly_r <= dly_r + 16'h0001;
  end

  // Byte assembly and word counters
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      shift_r <= 32'h00000000;
      bcnt_r  <= 2'h0;
      words_r <= 32'h00000000;
      left_r  <= 32'h00000000;
    end
    else if (state_r == ST_SECLOAD)
      bcnt_r  <= 2'h0;
    else if (src_vld)
    begin
      shift_r <= word_nxt;
      bcnt_r  <= bcnt_r + 2'h1;
      if (state_r == ST_SIZE && bcnt_r == BYTE_LAST)
      begin
        words_r <= word_nxt;
        left_r  <= word_nxt;
      end
      else if (state_r == ST_BODY && bcnt_r == BYTE_LAST)
        left_r  <= left_r - 32'h00000001;
    end
  end

  // OTP read pointer: security row, then image from row 0
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      otp_addr_r <= OTP_SEC_ROW;
      otp_pend_r <= 1'b0;
      from_otp_r <= 1'b0;
    end
    else if (state_r == ST_SECLOAD)
    begin
      from_otp_r <= OTP_RDATA_I[SEC_SECURE_BOOT];
      otp_addr_r <= OTP_IMG_ROW;
      otp_pend_r <= 1'b0;
    end
    else if (in_stream && from_otp_r)
    begin
      otp_pend_r <= 1'b1;
      if (src_vld && bcnt_r == BYTE_LAST)
      begin
        otp_addr_r <= otp_addr_r + 11'h001;
        otp_pend_r <= 1'b0;
      end
    end
  end

  // Program bytes into RAM from the lowest address
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ram_addr_r <= RAM_BASE;
      ram_we_r   <= 1'b0;
      ram_wd_r   <= 8'h00;
    end
    else if (state_r == ST_SECLOAD)
      ram_addr_r <= RAM_BASE;
    else
    begin
      ram_we_r <= src_vld && (state_r == ST_BODY);
      ram_wd_r <= src_byte;
      if (ram_we_r)
        ram_addr_r <= ram_addr_r + 16'h0001;
    end
  end

  // Security register: OTP load, then user field writes
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sec_r <= SEC_RESET;
    else if (state_r == ST_SECLOAD)
      sec_r <= OTP_RDATA_I;
    else if (wait_r && AVS_WRITE_I && AVS_ADDRESS_I == REG_SECURITY && !sec_r[SEC_MASTER_LOCK])
      sec_r[SEC_USER_HI:SEC_USER_LO] <= AVS_WRITEDATA_I[SEC_USER_HI:SEC_USER_LO];
  end

  // OTP programming requests from software
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      prog_data_r <= 32'h00000000;
      prog_r      <= 1'b0;
      prog_row_r  <= OTP_IMG_ROW;
    end
    else
    begin
      prog_r <= 1'b0;
      if (wait_r && AVS_WRITE_I && AVS_ADDRESS_I == REG_OTP_PDATA)
        prog_data_r <= AVS_WRITEDATA_I;
      if (wait_r && AVS_WRITE_I && AVS_ADDRESS_I == REG_OTP_PROG)
      begin
        prog_r     <= prog_ok(sec_r, AVS_WRITEDATA_I[OTP_AW-1:0]) && (state_r == ST_RUN);
        prog_row_r <= AVS_WRITEDATA_I[OTP_AW-1:0]; // Row shown on the OTP port while programming
      end
    end
  end

  // Bus slave: one wait cycle, then answer
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      wait_r <= 1'b0;
    else
      wait_r <= (AVS_READ_I || AVS_WRITE_I) && !wait_r;
  end

  // Registered outputs
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      GPIO_PULLDOWN_O      <= 1'b1;
      CPU_RUN_O            <= 1'b0;
      CPU_PC_O             <= RAM_BASE;
      BOOT_FAIL_O          <= 1'b0;
      JTAG_TILE_EN_O       <= 1'b0;
      LINK_ACCESS_EN_O     <= 1'b0;
      JTAG_OTP_EN_O        <= 1'b0;
      DEBUG_PIN_EN_O       <= 1'b0;
      OTP_REDUNDANT_O      <= 1'b0;
      SCAN_USER_CODE_EXT_O <= 10'h000;
      OTP_ADDR_O           <= OTP_SEC_ROW;
      OTP_PROG_O           <= 1'b0;
      OTP_WDATA_O          <= 32'h00000000;
      RAM_WE_O             <= 1'b0;
      RAM_ADDR_O           <= RAM_BASE;
      RAM_WDATA_O          <= 8'h00;
      AVS_WAITREQUEST_O    <= 1'b1;
      AVS_READDATA_O       <= UNMAPPED_READ;
    end
    else
    begin
      GPIO_PULLDOWN_O      <= (state_r == ST_RESET);
      CPU_RUN_O            <= (state_r == ST_RUN);
      CPU_PC_O             <= RAM_BASE;
      BOOT_FAIL_O          <= (state_r == ST_FAIL);
      JTAG_TILE_EN_O       <= !sec_r[SEC_JTAG_DIS];
      LINK_ACCESS_EN_O     <= !sec_r[SEC_LINK_DIS];
      JTAG_OTP_EN_O        <= !sec_r[SEC_JTAG_OTP_DIS];
      DEBUG_PIN_EN_O       <= !sec_r[SEC_DEBUG_DIS];
      OTP_REDUNDANT_O      <= sec_r[SEC_REDUNDANT];
      SCAN_USER_CODE_EXT_O <= sec_r[31:SEC_CODE_LO];
      OTP_ADDR_O           <= prog_r ? prog_row_r : otp_addr_r;
      OTP_PROG_O           <= prog_r;
      OTP_WDATA_O          <= prog_data_r;
      RAM_WE_O             <= ram_we_r;
      RAM_ADDR_O           <= ram_addr_r;
      RAM_WDATA_O          <= ram_wd_r;
      AVS_WAITREQUEST_O    <= !((AVS_READ_I || AVS_WRITE_I) && !wait_r);
      // Read data loaded with the accept, valid while waitrequest is low
      if (AVS_READ_I && !wait_r)
        case (AVS_ADDRESS_I)
          REG_SECURITY:  AVS_READDATA_O <= sec_r;
          REG_STATUS:    AVS_READDATA_O <= {23'h000000, state_r};
          REG_OTP_PDATA: AVS_READDATA_O <= prog_data_r;
          REG_CRC:       AVS_READDATA_O <= crc;
          default:       AVS_READDATA_O <= UNMAPPED_READ;
        endcase
    end
  end
endmodule

// >>> verif/tile_boot_loader_checker.sv
// Port checker for the tile boot loader
`timescale 1ns/100ps
module tile_boot_loader_checker
  import boot_pkg::*;
(
  // Clock, reset and bus
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic        AVS_WAITREQUEST_O,
  // Loader side
  input wire logic        FL_RD_O,
  input wire logic        FL_VLD_I,
  input wire logic        OTP_PROG_O,
  input wire logic        RAM_WE_O,
  input wire logic [15:0] RAM_ADDR_O,
  input wire logic        CPU_RUN_O,
  input wire logic [15:0] CPU_PC_O,
  input wire logic        BOOT_FAIL_O,
  input wire logic        GPIO_PULLDOWN_O,
  input wire logic        JTAG_TILE_EN_O,
  input wire logic [9:0]  SCAN_USER_CODE_EXT_O
);
  logic [11:0] cnt_r;
  logic        pend_r;
  logic        seen_r;
  logic [15:0] last_r;
  // Cycles since reset, saturating
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    if (!RST_N_I)
      cnt_r <= '0;
    else if (cnt_r != 12'hFFF)
      cnt_r <= cnt_r + 12'h001;
  // Flash request outstanding
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    if (!RST_N_I)
      pend_r <= 1'b0;
    else if (FL_RD_O)
      pend_r <= 1'b1;
    else if (FL_VLD_I)
      pend_r <= 1'b0;
  // Last RAM address written
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      seen_r <= 1'b0;
      last_r <= '0;
    end
    else if (RAM_WE_O)
    begin
      seen_r <= 1'b1;
      last_r <= RAM_ADDR_O;
    end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  property p_early; cnt_r < INT_RESET_CYC - 2 |-> GPIO_PULLDOWN_O && !FL_RD_O && !RAM_WE_O; endproperty
  a_early: assert property (p_early) else $error("boot began too soon");
  property p_flash; pend_r && !FL_VLD_I |-> !FL_RD_O; endproperty
  a_flash: assert property (p_flash) else $error("second flash request");
  property p_first; RAM_WE_O && !seen_r |-> RAM_ADDR_O == RAM_BASE; endproperty
  a_first: assert property (p_first) else $error("load not at base");
  property p_next; RAM_WE_O && seen_r |-> RAM_ADDR_O == last_r + 16'h0001; endproperty
  a_next: assert property (p_next) else $error("load address skipped");
  property p_run; CPU_RUN_O |-> CPU_PC_O == RAM_BASE && !RAM_WE_O && !GPIO_PULLDOWN_O; endproperty
  a_run: assert property (p_run) else $error("bad run state");
  property p_fail; BOOT_FAIL_O |=> BOOT_FAIL_O && !CPU_RUN_O; endproperty
  a_fail: assert property (p_fail) else $error("failed boot left");
  property p_gates; CPU_RUN_O && $past(CPU_RUN_O) |-> $stable({JTAG_TILE_EN_O, SCAN_USER_CODE_EXT_O}); endproperty
  a_gates: assert property (p_gates) else $error("gate moved");
  property p_prog; OTP_PROG_O |-> CPU_RUN_O; endproperty
  a_prog: assert property (p_prog) else $error("program before boot");
  property p_ack; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |-> ##[1:3] !AVS_WAITREQUEST_O; endproperty
  a_ack: assert property (p_ack) else $error("bus not answered");
  property p_pulse; !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O; endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
endmodule
bind tile_boot_loader tile_boot_loader_checker i_chk (.*);

// >>> verif/boot_mem_model.sv
// Behavioural serial flash and OTP array
`timescale 1ns/100ps
module boot_mem_model
  import boot_pkg::*;
(
  // Clock, reset and pacing
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        slow_i,
  // Flash byte port
  input  wire logic        fl_rd_i,
  input  wire logic [23:0] fl_addr_i,
  output logic             fl_vld_o,
  output logic      [7:0]  fl_data_o,
  // OTP read port
  input  wire logic [10:0] otp_addr_i,
  output logic      [31:0] otp_rdata_o
);
  logic [7:0]  fl_mem  [0:255];
  logic [31:0] otp_mem [0:OTP_ROWS-1];
  logic        busy_r;
  logic [2:0]  wait_r;
  logic [7:0]  addr_r;
  // Security row and image rows read directly
  assign otp_rdata_o = otp_mem[otp_addr_i];
  // Flash answers after a short or long wait
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      busy_r <= 1'b0;
      wait_r <= '0;
      addr_r <= '0;
      fl_vld_o <= 1'b0;
      fl_data_o <= '0;
    end
    else
    begin
      fl_vld_o <= 1'b0;
      fl_data_o <= ~fl_data_o; // No stale byte between answers
      if (fl_rd_i)
      begin
        busy_r <= 1'b1;
        addr_r <= fl_addr_i[7:0];
        wait_r <= slow_i ? 3'h4 : 3'h0;
      end
      else if (busy_r && wait_r != 3'h0)
        wait_r <= wait_r - 3'h1;
      else if (busy_r)
      begin
        busy_r <= 1'b0;
        fl_vld_o <= 1'b1;
        fl_data_o <= fl_mem[addr_r];
      end
    end
endmodule

// >>> verif/tile_boot_loader_bench.sv
// Self-checking bench of the tile boot loader
`timescale 1ns/100ps
module tile_boot_loader_bench;
  import boot_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic        slow  = 1'b0;
  logic [3:0]  adr   = 4'h0;
  logic [31:0] wd    = 32'h0;
  logic [31:0] seed  = 32'h00017A64;
  logic [31:0] rdat, otp_dat, pwd, lastpd;
  logic [23:0] fl_adr;
  logic [15:0] ra, pc;
  logic [10:0] otp_adr, lastrow;
  logic [9:0]  uc;
  logic [7:0]  fl_dat, rw;
  logic        wreq, fl_rd, fl_vld, prog, red, we, run, fail, pd, jt, lk, jo, dbg;
  logic [7:0]  q[$], s_q[$];
  int          fail_count = 0;
  int          compares   = 0;
  int          nprog      = 0;
  // Clock
  initial
    forever #5 clk = ~clk;
  tile_boot_loader i_tile_boot_loader (.CLK_SYS_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .FL_RD_O(fl_rd), .FL_ADDR_O(fl_adr),
    .FL_VLD_I(fl_vld), .FL_DATA_I(fl_dat), .OTP_ADDR_O(otp_adr), .OTP_RDATA_I(otp_dat),
    .OTP_PROG_O(prog), .OTP_WDATA_O(pwd), .OTP_REDUNDANT_O(red), .RAM_WE_O(we), .RAM_ADDR_O(ra),
    .RAM_WDATA_O(rw), .CPU_RUN_O(run), .CPU_PC_O(pc), .BOOT_FAIL_O(fail), .GPIO_PULLDOWN_O(pd),
    .JTAG_TILE_EN_O(jt), .LINK_ACCESS_EN_O(lk), .JTAG_OTP_EN_O(jo), .DEBUG_PIN_EN_O(dbg),
    .SCAN_USER_CODE_EXT_O(uc));
  boot_mem_model i_boot_mem_model (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .fl_rd_i(fl_rd),
    .fl_addr_i(fl_adr), .fl_vld_o(fl_vld), .fl_data_o(fl_dat), .otp_addr_i(otp_adr), .otp_rdata_o(otp_dat));
  // Count programming pulses
  always @(posedge clk)
    if (prog === 1'b1)
    begin
      nprog++;
      lastpd = pwd;
      lastrow = otp_adr;
    end
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Reference CRC over size and program bytes
  function automatic logic [31:0] crc_of();
    logic [31:0] c;
    c = CRC_PRESET;
    foreach (s_q[i])
    begin
      c ^= {24'h0, s_q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One Avalon access, held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (k = 0; k < 20 && wreq !== 1'b0; k++)
      @(posedge clk);
    if (k == 20)
    begin
      check(0, 1);
      end_of_test();
    end
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Boot one image of n words; mode 0 good, 1 no check, 2 bad check
  task automatic boot(input int n, input logic sec5, input int mode);
    logic [31:0] sec, w, v, e;
    int k, reads, n0;
    s_q = {};
    q = {};
    sec = lfsr();
    sec[5] = sec5;
    i_boot_mem_model.otp_mem[OTP_SEC_ROW] = sec;
    for (k = 0; k < n + 2; k++)
    begin
      w = k == 0 ? n : lfsr();
      if (k == n + 1)
        w = mode == 1 ? NO_CRC_MAGIC : crc_of() ^ (mode == 2);
      i_boot_mem_model.otp_mem[k] = w;
      for (int b = 0; b < 4; b++)
      begin
        i_boot_mem_model.fl_mem[4*k+b] = w[8*b+:8];
        if (k <= n)
          s_q.push_back(w[8*b+:8]);
        if (k > 0 && k <= n)
          q.push_back(w[8*b+:8]);
      end
    end
    slow <= sec[3];
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    check({pd, run}, 2'b10);
    rst_n <= 1'b1;
    reads = 0;
    for (k = 0; k < 4000 && run !== 1'b1 && fail !== 1'b1; k++)
    begin
      @(posedge clk);
      reads += fl_rd === 1'b1;
      if (we === 1'b1)
      begin
        check(ra, 4 * n - q.size());
        check(rw, q.size() ? q.pop_front() : 8'hFF);
      end
    end
    check(k < 4000, 1);
    if (k == 4000)
      end_of_test();
    check(q.size(), 0);
    check({run, fail, pc, pd}, {mode != 2, mode == 2, RAM_BASE, 1'b0});
    check(reads != 0, !sec5);
    check({jt, lk, jo, dbg, red, uc}, {~sec[0], ~sec[1], ~sec[13], ~sec[14], sec[7], sec[31:22]});
    bus(0, REG_STATUS, 0, v);
    check(v, mode == 2 ? ST_FAIL : ST_RUN);
    bus(0, REG_SECURITY, 0, v);
    check(v, sec);
    bus(0, REG_CRC, 0, v);
    if (mode == 0)
      check(v, crc_of());
    w = lfsr();
    bus(1, REG_SECURITY, w, v);
    bus(0, REG_SECURITY, 0, v);
    e = sec[12] ? sec : (sec & ~32'h003F8000) | (w & 32'h003F8000);
    check(v, e);
    bus(1, 4'hE, w, v);
    bus(0, 4'hF, 0, v);
    check(v, UNMAPPED_READ);
    n0 = nprog;
    bus(1, REG_OTP_PDATA, w, v);
    v = lfsr();
    bus(1, REG_OTP_PROG, {21'h0, v[10:0]}, e);
    repeat (3) @(posedge clk);
    e = (mode != 2) && !sec[12] && !sec[8 + v[10:9]];
    check(nprog - n0, e);
    if (e)
    begin
      check(lastpd, w);
      check(lastrow, v[10:0]);
    end
    $display("test n=%0d mode=%0d done", n, mode);
  endtask
  // Scenario table
  initial
  begin
    @(posedge clk);
    boot(2, 0, 0);
    boot(0, 0, 0);
    boot(3, 1, 0);
    boot(1, 0, 1);
    boot(2, 1, 2);
    boot(4, 0, 2);
    boot(1, 1, 1);
    end_of_test();
  end
endmodule
